/* acs_pkg.sv */
`default_nettype none
// shared constants for the sample/convert sequencer
package acs_pkg;
	// bus geometry
	localparam int ACS_ADDR_W = 8;
	localparam int ACS_DATA_W = 32;

	// register byte addresses
	localparam logic [7:0] ACS_ADR_CTRL = 8'h00;
	localparam logic [7:0] ACS_ADR_CFG = 8'h04;
	localparam logic [7:0] ACS_ADR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ACS_ADR_IRQ_MASK = 8'h0c;

	// control register field positions
	localparam int ACS_CTRL_DONE = 0;
	localparam int ACS_CTRL_SAMPLE = 1;
	localparam int ACS_CTRL_AUTO_SAMPLE_START = 2;
	localparam int ACS_CTRL_SIMULTANEOUS_SAMPLE_SELECT = 3;
	localparam int ACS_CTRL_GROUP = 4;
	localparam int ACS_CTRL_CODE_LO = 5;

	// configuration register field positions
	localparam int ACS_CFG_TWELVE = 0;
	localparam int ACS_CFG_CHANNEL_COUNT_SELECT_LO = 1;

	// interrupt status bit positions
	localparam int ACS_IRQ_DONE = 0;
	localparam int ACS_IRQ_IGNORED = 1;

	// trigger codes
	localparam logic [2:0] ACS_CODE_MANUAL = 3'h0;
	localparam logic [2:0] ACS_CODE_EXTERNAL_INTERRUPT_ZERO_PIN = 3'h1;
	localparam logic [2:0] ACS_CODE_TMR3 = 3'h2;
	localparam logic [2:0] ACS_CODE_PWM_SPECIAL = 3'h3;
	localparam logic [2:0] ACS_CODE_TMR5 = 3'h4;
	localparam logic [2:0] ACS_CODE_CHARGE_TIME_MEASURE_UNIT = 3'h6;
	localparam logic [2:0] ACS_CODE_COUNTER = 3'h7;

	// values after reset
	localparam logic [2:0] ACS_RST_CODE = 3'h0;
	localparam logic [1:0] ACS_RST_CHANNEL_COUNT_SELECT = 2'h0;
	localparam logic [1:0] ACS_RST_MASK = 2'h0;
	localparam logic [7:0] ACS_RST_COUNT = 8'h00;

	// sequencer states, one-hot
	typedef enum logic [2:0] {
		ACS_IDLE = 3'b001,
		ACS_SAMPLE = 3'b010,
		ACS_CONVERT = 3'b100
	} acs_state_t;
endpackage
`default_nettype wire

/* acs_sample_convert.sv */
// Our own choices: the register offsets and the Wishbone slave port.
`default_nettype none
module acs_sample_convert #(
	parameter int SAMPLE_CYCLES = 16 // auto-convert acquisition length
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic arst_n_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [acs_pkg::ACS_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [acs_pkg::ACS_DATA_W-1:0] wb_dat_i,
	output logic [acs_pkg::ACS_DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// trigger sources, one-cycle pulses except the pin
	input wire logic timer5_match_i,
	input wire logic timer3_match_i,
	input wire logic pwm_special_event_i,
	input wire logic external_interrupt_zero_pin_i,
	input wire logic charge_time_measure_unit_i,
	input wire logic [2:0] pwm_generator_trig_i,
	input wire logic [3:0] trigger_generator_output_i,
	// converter core
	output logic [3:0] sample_hold_o,
	output logic conv_start_o,
	output logic [1:0] conv_chan_o,
	input wire logic conv_done_i,
	// interrupt
	output logic irq_o
);
	import acs_pkg::*;

	localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_CYCLES - 1);

	// whole state of the block
	typedef struct packed {
		acs_state_t state;
		logic [2:0] trig_code; // trigger_source_code
		logic trig_group; // trigger_group_select
		logic simultaneous_sample_select; // simultaneous_sample_select as written
		logic auto_sample_start; // auto_sample_start
		logic twelve; // twelve_bit_mode_select
		logic [1:0] channel_count_select; // channel_count_select
		logic done; // conversion done flag
		logic [1:0] chan; // channel under conversion
		logic conv_start; // start pulse to the core
		logic [1:0] irq_stat; // sticky events
		logic [1:0] irq_mask; // enables
		logic ack; // bus answer
		logic [31:0] rdata; // captured read word
		logic external_interrupt_zero_pin_prev; // pin history for edge detect
		logic [7:0] smp_cnt; // acquisition counter
	} acs_regs_t;

	acs_regs_t cur_r;
	acs_regs_t cur_nxt;

	// highest channel converted for the current setup
	function automatic logic [1:0] acs_last_chan(input logic twelve, input logic [1:0] channel_count_select);
		logic [1:0] last;
		last = 2'h0;
		if (twelve) begin
			last = 2'h0; // single amplifier in twelve-bit mode
		end else if (channel_count_select[1]) begin
			last = 2'h3;
		end else if (channel_count_select[0]) begin
			last = 2'h1;
		end
		return last;
	endfunction

	// effective simultaneous mode
	function automatic logic acs_simul(input logic simultaneous_sample_select, input logic twelve);
		return simultaneous_sample_select & ~twelve;
	endfunction

	// selected trigger, manual code gives none here
	function automatic logic acs_trig_pick(
		input logic grp,
		input logic [2:0] code,
		input logic t5,
		input logic t3,
		input logic pwm_sp,
		input logic external_interrupt_zero_pin_edge,
		input logic ctr,
		input logic charge_time_measure_unit,
		input logic [2:0] pwmg,
		input logic [3:0] tgo
	);
		logic hit;
		hit = 1'b0;
		if (grp) begin
			case (code)
				3'h0, 3'h1, 3'h2: hit = pwmg[code[1:0]];
				3'h3: hit = tgo[0];
				3'h4: hit = tgo[1];
				3'h5: hit = tgo[2];
				3'h6: hit = tgo[3];
				default: hit = 1'b0; // reserved code never fires
			endcase
		end else begin
			case (code)
				ACS_CODE_TMR5: hit = t5;
				ACS_CODE_TMR3: hit = t3;
				ACS_CODE_PWM_SPECIAL: hit = pwm_sp;
				ACS_CODE_EXTERNAL_INTERRUPT_ZERO_PIN: hit = external_interrupt_zero_pin_edge;
				ACS_CODE_COUNTER: hit = ctr;
				ACS_CODE_CHARGE_TIME_MEASURE_UNIT: hit = charge_time_measure_unit;
				default: hit = 1'b0; // manual and reserved
			endcase
		end
		return hit;
	endfunction

	// decoded bus and trigger terms
	logic req; // new request waiting for ack
	logic acc; // access completes at this edge
	logic wr_ctrl; // completing write to control
	logic wr_cfg; // completing write to configuration
	logic wr_mask; // completing write to mask
	logic rd_stat; // completing read of status
	logic manual; // manual trigger mode
	logic external_interrupt_zero_pin_edge; // rising edge on the pin
	logic ctr_hit; // acquisition counter expired
	logic hw_trig; // selected hardware trigger
	logic sw_trig; // software ended manual sampling
	logic sw_start; // software asks for sampling
	logic [1:0] last_chan;
	logic [15:0] ctrl_word;

	assign req = wb_cyc_i & wb_stb_i & ~cur_r.ack;
	assign acc = wb_cyc_i & wb_stb_i & cur_r.ack;
	assign wr_ctrl = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == ACS_ADR_CTRL);
	assign wr_cfg = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == ACS_ADR_CFG);
	assign wr_mask = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == ACS_ADR_IRQ_MASK);
	assign rd_stat = acc & ~wb_we_i & (wb_adr_i == ACS_ADR_IRQ_STAT);
	assign manual = ~cur_r.trig_group & (cur_r.trig_code == ACS_CODE_MANUAL);
	assign external_interrupt_zero_pin_edge = external_interrupt_zero_pin_i & ~cur_r.external_interrupt_zero_pin_prev;
	assign ctr_hit = (cur_r.state == ACS_SAMPLE) & (cur_r.smp_cnt == SAMPLE_LAST);
	assign hw_trig = acs_trig_pick(cur_r.trig_group, cur_r.trig_code, timer5_match_i,
		timer3_match_i, pwm_special_event_i, external_interrupt_zero_pin_edge, ctr_hit, charge_time_measure_unit_i,
		pwm_generator_trig_i, trigger_generator_output_i);
	assign sw_trig = wr_ctrl & manual & ~wb_dat_i[ACS_CTRL_SAMPLE];
	assign sw_start = wr_ctrl & wb_dat_i[ACS_CTRL_SAMPLE];
	assign last_chan = acs_last_chan(cur_r.twelve, cur_r.channel_count_select);

	// control readback, sample bit mirrors the acquiring state
	assign ctrl_word = {8'h00, cur_r.trig_code, cur_r.trig_group,
		acs_simul(cur_r.simultaneous_sample_select, cur_r.twelve), cur_r.auto_sample_start,
		cur_r.state == ACS_SAMPLE, cur_r.done};

	// next-state logic for the whole block
	always_comb begin
		cur_nxt = cur_r;
		cur_nxt.conv_start = 1'b0;
		cur_nxt.external_interrupt_zero_pin_prev = external_interrupt_zero_pin_i;
		// ack one cycle after the request, dropped the next
		cur_nxt.ack = req;
		if (req) begin
			unique case (wb_adr_i)
				ACS_ADR_CTRL: cur_nxt.rdata = {16'h0000, ctrl_word};
				ACS_ADR_CFG: cur_nxt.rdata = {29'h0, cur_r.channel_count_select, cur_r.twelve};
				ACS_ADR_IRQ_STAT: cur_nxt.rdata = {30'h0, cur_r.irq_stat};
				ACS_ADR_IRQ_MASK: cur_nxt.rdata = {30'h0, cur_r.irq_mask};
				default: cur_nxt.rdata = 32'h0; // unmapped reads zero
			endcase
		end
		// plain configuration fields
		if (wr_ctrl) begin
			cur_nxt.trig_code = wb_dat_i[ACS_CTRL_CODE_LO +: 3];
			cur_nxt.trig_group = wb_dat_i[ACS_CTRL_GROUP];
			cur_nxt.simultaneous_sample_select = wb_dat_i[ACS_CTRL_SIMULTANEOUS_SAMPLE_SELECT];
			cur_nxt.auto_sample_start = wb_dat_i[ACS_CTRL_AUTO_SAMPLE_START];
			// writing zero clears, a one is ignored, nothing else moves
			if (!wb_dat_i[ACS_CTRL_DONE]) begin
				cur_nxt.done = 1'b0;
			end
		end
		if (wr_cfg) begin
			cur_nxt.twelve = wb_dat_i[ACS_CFG_TWELVE];
			cur_nxt.channel_count_select = wb_dat_i[ACS_CFG_CHANNEL_COUNT_SELECT_LO +: 2];
		end
		if (wr_mask) begin
			cur_nxt.irq_mask = wb_dat_i[1:0];
		end
		// read clears only the bits the reader actually saw
		if (rd_stat) begin
			cur_nxt.irq_stat = cur_r.irq_stat & ~cur_r.rdata[1:0];
		end
		// sequencer
		unique case (cur_r.state)
			ACS_IDLE: begin
				// holding: only software restarts sampling
				if (sw_start) begin
					cur_nxt.state = ACS_SAMPLE;
					cur_nxt.smp_cnt = ACS_RST_COUNT;
				end
				if (hw_trig) begin
					cur_nxt.irq_stat[ACS_IRQ_IGNORED] = 1'b1;
				end
			end
			ACS_SAMPLE: begin
				cur_nxt.smp_cnt = cur_r.smp_cnt + 8'h01;
				// manual clear or hardware trigger ends acquisition
				if ((manual & sw_trig) | (~manual & hw_trig)) begin
					cur_nxt.state = ACS_CONVERT;
					cur_nxt.chan = 2'h0;
					cur_nxt.conv_start = 1'b1;
					cur_nxt.done = 1'b0;
				end
			end
			ACS_CONVERT: begin
				if (hw_trig) begin
					cur_nxt.irq_stat[ACS_IRQ_IGNORED] = 1'b1;
				end
				if (conv_done_i && !cur_r.conv_start) begin
					if (cur_r.chan == last_chan) begin
						// set after any software clear, so the event wins
						cur_nxt.done = 1'b1;
						cur_nxt.irq_stat[ACS_IRQ_DONE] = 1'b1;
						cur_nxt.smp_cnt = ACS_RST_COUNT;
						cur_nxt.state = cur_r.auto_sample_start ? ACS_SAMPLE : ACS_IDLE;
					end else begin
						// next channel; held since the start if simultaneous, from this edge if not
						cur_nxt.chan = cur_r.chan + 2'h1;
						cur_nxt.conv_start = 1'b1;
					end
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cur_r <= '{state: ACS_IDLE, trig_code: ACS_RST_CODE, trig_group: 1'b0,
				simultaneous_sample_select: 1'b0, auto_sample_start: 1'b0, twelve: 1'b0, channel_count_select: ACS_RST_CHANNEL_COUNT_SELECT, done: 1'b0,
				chan: 2'h0, conv_start: 1'b0, irq_stat: 2'h0, irq_mask: ACS_RST_MASK,
				ack: 1'b0, rdata: 32'h0, external_interrupt_zero_pin_prev: 1'b0, smp_cnt: ACS_RST_COUNT};
		end else begin
			cur_r <= cur_nxt;
		end
	end

	// per-channel acquire enables
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_hold
			logic used;
			assign used = (2'(gi) <= last_chan);
			// simultaneous: all hold together; else a channel holds when its turn comes
			assign sample_hold_o[gi] = used & ((cur_r.state == ACS_SAMPLE) |
				((cur_r.state == ACS_CONVERT) & ~acs_simul(cur_r.simultaneous_sample_select, cur_r.twelve) &
				(2'(gi) > cur_r.chan)));
		end
	endgenerate

	// outputs
	assign wb_ack_o = cur_r.ack;
	assign wb_dat_o = cur_r.ack ? cur_r.rdata : 32'h0;
	assign conv_start_o = cur_r.conv_start;
	assign conv_chan_o = cur_r.chan;
	assign irq_o = |(cur_r.irq_stat & cur_r.irq_mask);

	// software cannot set the done flag with a write of one
	// the flag only changes at the start or the end of a conversion otherwise

	// checks
	property p_manual_start;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(cur_r.state == ACS_SAMPLE && manual && sw_trig)
			|=> conv_start_o && conv_chan_o == 2'h0 && !sample_hold_o[0];
	endproperty
	a_manual_start: assert property (p_manual_start)
		else $error("manual clear did not start conversion");

	property p_timer5;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(cur_r.state == ACS_SAMPLE && !cur_r.trig_group &&
			cur_r.trig_code == ACS_CODE_TMR5 && timer5_match_i)
			|=> conv_start_o ##1 (cur_r.state == ACS_CONVERT);
	endproperty
	a_timer5: assert property (p_timer5)
		else $error("timer5 match did not end sampling");

	property p_reserved;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(cur_r.state == ACS_SAMPLE && !cur_r.trig_group && cur_r.trig_code == 3'h5)
			|=> cur_r.state == ACS_SAMPLE;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved trigger code left sampling");

	property p_autostart;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(cur_r.state == ACS_CONVERT && conv_done_i && !cur_r.conv_start &&
			cur_r.chan == last_chan && cur_r.auto_sample_start)
			|=> ctrl_word[ACS_CTRL_SAMPLE] && cur_r.done;
	endproperty
	a_autostart: assert property (p_autostart)
		else $error("auto-start did not resume sampling");

	property p_no_autostart;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(cur_r.state == ACS_IDLE && !sw_start) |=> !ctrl_word[ACS_CTRL_SAMPLE];
	endproperty
	a_no_autostart: assert property (p_no_autostart)
		else $error("sampling began without software");

	property p_done_cleared;
		@(posedge mclk_i) disable iff (!arst_n_i)
		$rose(cur_r.state == ACS_CONVERT) |-> !cur_r.done && conv_start_o;
	endproperty
	a_done_cleared: assert property (p_done_cleared)
		else $error("done not cleared at conversion start");

	property p_done_sticky;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(cur_r.done && !wr_ctrl && cur_r.state != ACS_SAMPLE) |=> cur_r.done;
	endproperty
	a_done_sticky: assert property (p_done_sticky)
		else $error("done dropped by itself");

	property p_clear_quiet;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(wr_ctrl && cur_r.state == ACS_CONVERT && !conv_done_i && !hw_trig)
			|=> $stable(cur_r.state) && $stable(cur_r.chan);
	endproperty
	a_clear_quiet: assert property (p_clear_quiet)
		else $error("control write disturbed conversion");

	property p_simultaneous_sample_select_zero;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(req && !wb_we_i && wb_adr_i == ACS_ADR_CTRL && cur_r.twelve)
			|=> wb_ack_o && !wb_dat_o[ACS_CTRL_SIMULTANEOUS_SAMPLE_SELECT];
	endproperty
	a_simultaneous_sample_select_zero: assert property (p_simultaneous_sample_select_zero)
		else $error("simultaneous bit read nonzero in twelve-bit mode");

	property p_ignored;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(cur_r.state == ACS_IDLE && hw_trig && !sw_start)
			|=> !conv_start_o ##1 !conv_start_o;
	endproperty
	a_ignored: assert property (p_ignored)
		else $error("trigger outside sampling started conversion");

	property p_simul_hold;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(cur_r.state == ACS_CONVERT && acs_simul(cur_r.simultaneous_sample_select, cur_r.twelve))
			|-> sample_hold_o == 4'h0;
	endproperty
	a_simul_hold: assert property (p_simul_hold)
		else $error("channel acquiring during simultaneous hold");

	property p_seq_hold;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(cur_r.state == ACS_CONVERT && !acs_simul(cur_r.simultaneous_sample_select, cur_r.twelve) &&
			cur_r.channel_count_select[1] && !cur_r.twelve && cur_r.chan == 2'h0)
			|-> sample_hold_o == 4'he;
	endproperty
	a_seq_hold: assert property (p_seq_hold)
		else $error("sequential channels not held one by one");
endmodule
`default_nettype wire

/* acs_conv_model.sv */
`default_nettype none
// converter core stand-in: answers each start with a done pulse
module acs_conv_model #(
	parameter int DELAY = 6 // cycles from start to done
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic arst_n_i,
	// start in, done out
	input wire logic conv_start_i,
	output logic conv_done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt_r; // cycles left, 0 = no conversion running
	// countdown; done never in the start cycle, the block ignores it there
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_r <= 0;
			conv_done_o <= 1'b0;
		end else begin
			conv_done_o <= (cnt_r == 1);
			if (conv_start_i) begin
				cnt_r <= DELAY;
			end else if (cnt_r > 0) begin
				cnt_r <= cnt_r - 1;
			end
		end
	end
endmodule
`default_nettype wire

/* tb_adc_sample_convert_control.sv */
`default_nettype none
// bench: scenario tasks over the wishbone port and trigger lines
module tb_adc_sample_convert_control import acs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SC = 8; // shortened acquisition count
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat;
	logic wb_ack;
	logic [11:0] trg = 12'h000; // all trigger lines, see port map
	logic [3:0] s_h;
	logic conv_start;
	logic conv_done;
	logic irq;
	logic [1:0] conv_chan;
	int n_fail = 0;
	int checked = 0;
	int n_start = 0; // conversion starts seen
	logic [7:0] chans = 8'h00; // last four channel indices
	logic [31:0] q;
	int k;
	int n0;
	acs_sample_convert #(.SAMPLE_CYCLES(SC)) u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.timer5_match_i(trg[0]), .timer3_match_i(trg[1]), .pwm_special_event_i(trg[2]),
		.external_interrupt_zero_pin_i(trg[3]), .charge_time_measure_unit_i(trg[4]),
		.pwm_generator_trig_i(trg[7:5]), .trigger_generator_output_i(trg[11:8]),
		.sample_hold_o(s_h), .conv_start_o(conv_start), .conv_chan_o(conv_chan),
		.conv_done_i(conv_done), .irq_o(irq));
	acs_conv_model #(.DELAY(6)) u_core (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
		.conv_start_i(conv_start), .conv_done_o(conv_done));
	// 25 MHz clock
	initial begin
		forever #20 mclk_i = ~mclk_i;
	end
	// log every start and its channel
	always @(posedge mclk_i) begin
		if (conv_start === 1'b1) begin
			n_start <= n_start + 1;
			chans <= {chans[5:0], conv_chan};
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// one classic cycle; waits for ack with a bound
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d,
		input logic [3:0] sel, output logic [31:0] rq);
		int n;
		n = 0;
		@(posedge mclk_i);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} <= {2'b11, we, adr, d, sel};
		do begin
			@(posedge mclk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		rq = wb_rdat;
		if (n >= 20) chk(32'h0, 32'h1, "no ack");
		{wb_cyc, wb_stb, wb_we} <= 3'b000;
	endtask
	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, adr, d, 4'h1, dummy);
	endtask
	task automatic rd(input logic [7:0] adr, output logic [31:0] rq);
		bus(1'b0, adr, 32'h0, 4'hf, rq);
	endtask
	// control word: code, group, simultaneous, auto, sample, done
	function automatic logic [31:0] ctl(input logic g, input logic [2:0] c,
		input logic sim, input logic au, input logic smp);
		return {24'h0, c, g, sim, au, smp, 1'b0};
	endfunction
	task automatic do_reset();
		@(posedge mclk_i);
		arst_n_i <= 1'b0;
		trg <= 12'h000;
		repeat (10) @(posedge mclk_i);
		arst_n_i <= 1'b1;
	endtask
	task automatic fire(input logic [11:0] m);
		@(posedge mclk_i);
		trg <= m;
		@(posedge mclk_i);
		trg <= 12'h000;
	endtask
	task automatic wait_start(output int kk);
		kk = 0;
		do begin
			@(posedge mclk_i);
			kk++;
		end while (conv_start !== 1'b1 && kk < 60);
		if (kk >= 60) chk(32'h0, 32'h1, "no start");
	endtask
	task automatic wait_done(output logic [31:0] rq);
		int n;
		n = 0;
		do begin
			rd(ACS_ADR_CTRL, rq);
			n++;
		end while (rq[0] !== 1'b1 && n < 40);
		// a conversion that never finishes must not pass silently
		if (rq[0] !== 1'b1) chk(32'h0, 32'h1, "no done");
	endtask
	// trigger line for a group and code; -1 reserved, -2 not a line
	function automatic int line_of(input logic g, input logic [2:0] c);
		if (g) return (c == 3'h7) ? -1 : 5 + int'(c);
		case (c)
			3'h1: return 3;
			3'h2: return 1;
			3'h3: return 2;
			3'h4: return 0;
			3'h6: return 4;
			3'h5: return -1;
			default: return -2;
		endcase
	endfunction
	task automatic t_bus();
		logic [7:0] a [5] = '{ACS_ADR_CTRL, ACS_ADR_CFG, ACS_ADR_IRQ_STAT, ACS_ADR_IRQ_MASK, 8'h10};
		do_reset();
		wr(8'h10, 32'hffffffff);
		foreach (a[i]) begin
			rd(a[i], q);
			chk(q, 32'h0, "value after reset");
		end
		bus(1'b1, ACS_ADR_CFG, 32'h7, 4'h0, q);
		rd(ACS_ADR_CFG, q);
		chk(q, 32'h0, "write without sel0");
		$display("test bus done");
	endtask
	task automatic t_manual();
		do_reset();
		wr(ACS_ADR_IRQ_MASK, 32'h1);
		wr(ACS_ADR_CTRL, ctl(0, 3'h0, 0, 0, 1));
		rd(ACS_ADR_CTRL, q);
		chk(q, 32'h2, "sampling after set");
		chk(s_h[0], 1'b1, "channel zero acquiring");
		wr(ACS_ADR_CTRL, ctl(0, 3'h0, 0, 0, 0));
		wait_done(q);
		chk(q, 32'h1, "done after manual convert");
		chk(irq, 1'b1, "done interrupt");
		rd(ACS_ADR_IRQ_STAT, q);
		chk(q, 32'h1, "done status");
		repeat (2) @(posedge mclk_i);
		chk(irq, 1'b0, "interrupt after read clear");
		wr(ACS_ADR_CTRL, ctl(0, 3'h0, 0, 0, 1));
		rd(ACS_ADR_CTRL, q);
		// every ctl() word carries done as zero, so the flag clears here
		chk(q, 32'h2, "done cleared by writing zero");
		wr(ACS_ADR_CTRL, 32'h3);
		rd(ACS_ADR_CTRL, q);
		chk(q, 32'h2, "write one to done ignored");
		wr(ACS_ADR_CTRL, 32'h2);
		rd(ACS_ADR_CTRL, q);
		chk(q, 32'h2, "clear done keeps sampling");
		wr(ACS_ADR_CTRL, 32'h0);
		rd(ACS_ADR_CTRL, q);
		wait_done(q);
		chk(q, 32'h1, "second conversion completes");
		$display("test manual done");
	endtask
	task automatic t_triggers();
		int ln;
		for (int g = 0; g < 2; g++) begin
			for (int c = 0; c < 8; c++) begin
				ln = line_of(g[0], c[2:0]);
				if (ln == -2) continue;
				do_reset();
				wr(ACS_ADR_CTRL, ctl(g[0], c[2:0], 0, 0, 1));
				n0 = n_start;
				fire((ln < 0) ? 12'hfff : ~(12'h001 << ln));
				repeat (3) @(posedge mclk_i);
				chk(n_start, n0, "unselected or reserved fired");
				if (ln >= 0) begin
					fire(12'h001 << ln);
					repeat (3) @(posedge mclk_i);
					chk(n_start, n0 + 1, "selected trigger");
					rd(ACS_ADR_CTRL, q);
					chk(q, ctl(g[0], c[2:0], 0, 0, 0), "sample cleared by trigger");
					wait_done(q);
				end
			end
		end
		$display("test triggers done");
	endtask
	task automatic t_counter();
		do_reset();
		wr(ACS_ADR_CTRL, ctl(0, 3'h7, 0, 1, 1));
		wait_start(k);
		chk(k >= SC && k <= SC + 2, 1'b1, "counter sampling length");
		wait_done(q);
		chk(q, ctl(0, 3'h7, 0, 1, 1) | 32'h1, "auto resample sets sample");
		wait_start(k);
		rd(ACS_ADR_CTRL, q);
		chk(q, ctl(0, 3'h7, 0, 1, 0), "done cleared at start");
		wr(ACS_ADR_CTRL, ctl(0, 3'h7, 0, 0, 0));
		wait_done(q);
		chk(q, ctl(0, 3'h7, 0, 0, 0) | 32'h1, "stops without auto");
		$display("test counter done");
	endtask
	// config, simultaneous bit, expected hold pattern, conversions
	task automatic chan_case(input logic [31:0] cfg, input logic sim, input logic [3:0] hold,
		input int nconv, input logic [7:0] order);
		do_reset();
		wr(ACS_ADR_CFG, cfg);
		wr(ACS_ADR_CTRL, ctl(0, 3'h0, sim, 0, 1));
		rd(ACS_ADR_CTRL, q);
		chk(q[3], sim & ~cfg[0], "simultaneous readback");
		n0 = n_start;
		// keep the simultaneous bit while ending manual sampling
		wr(ACS_ADR_CTRL, ctl(0, 3'h0, sim, 0, 0));
		wait_start(k);
		chk(s_h & (cfg[0] ? 4'h1 : 4'hf), hold, "hold pattern");
		wait_done(q);
		chk(n_start - n0, nconv, "conversion count");
		chk(chans & ((8'h01 << (2 * nconv)) - 8'h01), order, "channel order");
	endtask
	task automatic t_chans();
		chan_case(32'h4, 1'b1, 4'h0, 4, 8'h1b);
		chan_case(32'h4, 1'b0, 4'he, 4, 8'h1b);
		chan_case(32'h2, 1'b1, 4'h0, 2, 8'h01);
		chan_case(32'h5, 1'b1, 4'h0, 1, 8'h00);
		$display("test channels done");
	endtask
	task automatic t_ignored();
		do_reset();
		wr(ACS_ADR_IRQ_MASK, 32'h2);
		wr(ACS_ADR_CTRL, ctl(0, 3'h4, 0, 0, 0));
		n0 = n_start;
		fire(12'h001);
		repeat (3) @(posedge mclk_i);
		chk(n_start, n0, "trigger while idle");
		chk(irq, 1'b1, "ignored trigger interrupt");
		rd(ACS_ADR_IRQ_STAT, q);
		chk(q, 32'h2, "ignored status");
		wr(ACS_ADR_IRQ_MASK, 32'h0);
		fire(12'h001);
		repeat (3) @(posedge mclk_i);
		chk(irq, 1'b0, "masked interrupt");
		$display("test ignored done");
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		t_bus();
		t_manual();
		t_triggers();
		t_counter();
		t_chans();
		t_ignored();
		test_done();
	end
	// watchdog, far beyond the expected run of under a thousand cycles
	initial begin
		repeat (40000) @(posedge mclk_i);
		n_fail++;
		test_done();
	end
endmodule
`default_nettype wire
